// *** rsc_regs.svh ***
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RSC_IDX_STATUS 16'hfc70
`define RSC_IDX_CONTROL 16'hfc71
`define RSC_IDX_ENC_PTR 16'hfc72
`define RSC_IDX_ENC_LEN 16'hfc73
`define RSC_IDX_DEC_PTR 16'hfc74
`define RSC_IDX_DEC_LEN 16'hfc75
`define RSC_IDX_READ_PORT 16'hfc76
`define RSC_IDX_TOTALS 16'hfc7d
`define RSC_IDX_SHARED 16'hfc7e
`define RSC_RST_REG 16'h0000

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define RSC_ST_CLEAN 0
`define RSC_ST_HAS_ERR 1
`define RSC_ST_UNREC 2
`define RSC_ST_FIX_A 3
`define RSC_ST_FIX_BUSY 4
`define RSC_ST_FIX_B 5
`define RSC_ST_FIX_OVF 6
`define RSC_ST_PAIRS 12:8

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define RSC_CF_ENC_MODE 0
`define RSC_CF_ENC_ENA 1
`define RSC_CF_ENC_START 2
`define RSC_CF_ENC_FLASH 3
`define RSC_CF_PAR_SEL 7:4
`define RSC_CF_DEC_MODE 8
`define RSC_CF_DEC_ENA 9
`define RSC_CF_DEC_START 10
`define RSC_CF_DEC_END 11
`define RSC_CF_DEC_WIDE 12
`define RSC_CF_DEC_FLASH 13

// ----------------------------------------------------------------
// Shared peripheral status fields
// ----------------------------------------------------------------
`define RSC_XS_ENC_DONE 6
`define RSC_XS_DEC_DONE 7
`define RSC_XS_CORR_DONE 8
`define RSC_XS_IRQ_ENA 14

// ----------------------------------------------------------------
// Code geometry and field polynomials
// ----------------------------------------------------------------
`define RSC_LONG_N 11'd1023
`define RSC_LONG_T 6'd4
`define RSC_LONG_NSYM 6'd8
`define RSC_SHORT_N 11'd255
`define RSC_SHORT_T 6'd16
`define RSC_SHORT_NSYM 6'd32
`define RSC_POLY_LONG 11'h409
`define RSC_POLY_SHORT 11'h11d

`endif

// *** rsc_pkg.sv ***
package rsc_pkg;

	typedef logic [9:0] rsc_sym_t;
	typedef logic [32:0][9:0] rsc_tab_t;

	typedef enum logic [2:0] {FIX_IDLE, FIX_BM, FIX_OMEGA, FIX_CHIEN, FIX_WLOC, FIX_WMAG, FIX_END} rsc_fix_e;

	// Memory fetch engine of one direction
	typedef struct packed {
		logic have;
		logic lo;
		logic pend;
		logic [10:0] addr;
		logic [15:0] left;
		logic [15:0] word;
	} rsc_eng_s;

	// Peripheral memory request
	typedef struct packed {
		logic req;
		logic we;
		logic [10:0] addr;
		logic [15:0] wdata;
	} rsc_mem_req_s;

	// Flash data path symbol
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} rsc_flash_s;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] encPtr;
		logic [15:0] encLen;
		logic [15:0] decPtr;
		logic [15:0] decLen;
		logic irqEna;
		logic corrFlag;
		logic decFlag;
		logic encFlag;
		logic clean;
		logic hasErr;
		logic unrec;
		logic fixA;
		logic fixBusy;
		logic fixB;
		logic fixOvf;
		logic [4:0] pairCnt;
		logic [5:0] totalCnt;
		rsc_eng_s enc;
		rsc_eng_s dec;
		rsc_tab_t par;
		rsc_tab_t syn;
		rsc_tab_t lam;
		rsc_tab_t prevB;
		rsc_tab_t omg;
		logic [5:0] lenL;
		logic [5:0] step;
		rsc_sym_t gamma;
		rsc_fix_e fix;
		logic [10:0] decCnt;
		logic [10:0] chienPos;
		logic [4:0] pairs;
		logic [5:0] roots;
		logic [15:0] errLoc;
		rsc_sym_t errMag;
		logic [15:0] readWord;
		logic [31:0] prdata;
		logic pslverr;
	} rsc_state_s;

endpackage

// *** rsc_codec.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "rsc_regs.svh"
// Contract
// R1 - Long code: n 1023, t 4, 10-bit checks
// R2 - Short code: n 255, t 16, 8-bit
// R3 - Correct t symbol errors, detect 2t
// R4 - Long page: 80 check bits as bytes
// R5 - Long checks read as five 16-bit words
// R6 - Long check symbols follow fixed packing map
// R7 - Short checks: sixteen big-endian words
// R8 - Long decode: data first, then checks
// R9 - Software puts checks in low bits
// R10 - Report totals; pairs only for data
// R11 - Software XORs magnitude into data
// R12 - One irq line, gated by enable bit
// R13 - Shared flags at bits 8, 7, 6
// R14 - Pair count in status 12:8
// R15 - Bit 6 flags uncorrectable fix
// R16 - Fix progress bits 3,4,5; then irq
// R17 - Bit 2 fatal, only after end
// R18 - Bit 1 errors; starts fix automatically
// R19 - Bit 0 clean after code end
// R20 - Decoder control fields at 13:8
// R21 - Encoder control fields at 7:0
// R22 - Code end clears after one cycle
// R23 - Code start clears on first symbol
// R24 - Decoder feed widens, counts, signals done; the code sets no decode-done flag in wide mode
// R25 - Encoder feed widens bytes, signals done
// R26 - Read port shows selected check word
module rsc_codec #(
	parameter int APB_AW = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Peripheral memory port
	output rsc_pkg::rsc_mem_req_s memReq,
	input wire logic [15:0] memRdata,
	// Flash data path
	input wire rsc_pkg::rsc_flash_s flashTx,
	input wire rsc_pkg::rsc_flash_s flashRx,
	// Shared interrupt
	output logic sharedPeriphIrq
);
	import rsc_pkg::*;

	// ----------------------------------------------------------------
	// Galois field arithmetic
	// ----------------------------------------------------------------
	// Shift-and-add product; short mode operands stay below 256
	function automatic rsc_sym_t gfMul(input rsc_sym_t a, input rsc_sym_t b, input logic isLong);
		logic [10:0] r;
		logic [10:0] poly;
		r = '0;
		poly = isLong ? `RSC_POLY_LONG : `RSC_POLY_SHORT;
		for (int i = 9; i >= 0; i--) begin
			r = {r[9:0], 1'b0};
			if (isLong ? r[10] : r[8]) begin
				r = r ^ poly;
			end
			if (b[i]) begin
				r = r ^ {1'b0, a};
			end
		end
		return r[9:0];
	endfunction

	// Inverse as x^(2^m-2), a chain of squarings
	function automatic rsc_sym_t gfInv(input rsc_sym_t x, input logic isLong);
		rsc_sym_t s;
		rsc_sym_t r;
		s = x;
		r = 10'h001;
		for (int k = 1; k < 10; k++) begin
			s = gfMul(s, s, isLong);
			if (k < (isLong ? 10 : 8)) begin
				r = gfMul(r, s, isLong);
			end
		end
		return r;
	endfunction

	// Powers of alpha or of its inverse
	function automatic rsc_tab_t powTab(input logic isLong, input logic neg);
		rsc_tab_t t;
		rsc_sym_t a;
		rsc_sym_t stepv;
		stepv = neg ? gfInv(10'h002, isLong) : 10'h002;
		a = 10'h001;
		for (int i = 0; i < 33; i++) begin
			t[i] = a;
			a = gfMul(a, stepv, isLong);
		end
		return t;
	endfunction

	// Generator with roots alpha^0 .. alpha^(nsym-1)
	function automatic rsc_tab_t genPoly(input logic isLong, input int nsym);
		rsc_tab_t g;
		rsc_sym_t a;
		g = '0;
		g[0] = 10'h001;
		a = 10'h001;
		for (int i = 0; i < nsym; i++) begin
			for (int j = 32; j > 0; j--) begin
				g[j] = g[j-1] ^ gfMul(g[j], a, isLong);
			end
			g[0] = gfMul(g[0], a, isLong);
			a = gfMul(a, 10'h002, isLong);
		end
		return g;
	endfunction

	localparam rsc_tab_t APOW_L = powTab(1'b1, 1'b0);
	localparam rsc_tab_t APOW_S = powTab(1'b0, 1'b0);
	localparam rsc_tab_t AINV_L = powTab(1'b1, 1'b1);
	localparam rsc_tab_t AINV_S = powTab(1'b0, 1'b1);
	localparam rsc_tab_t GEN_L = genPoly(1'b1, 8); // R1
	localparam rsc_tab_t GEN_S = genPoly(1'b0, 32); // R2

	// Address decode needs the full index above two alignment bits
	if (APB_AW < 18 || APB_AW > 32) begin : g_aw_check
		$error("rsc_codec: APB_AW must be 18 to 32");
	end

	// ----------------------------------------------------------------
	// State and working signals
	// ----------------------------------------------------------------
	rsc_state_s st;
	rsc_state_s next_st;
	logic eLong;
	logic dLong;
	logic [5:0] encNsym;
	logic [5:0] decNsym;
	logic fixWrite;
	logic encGo;
	logic decGo;
	logic encSymV;
	logic decSymV;
	rsc_sym_t encSym;
	rsc_sym_t decSym;
	rsc_sym_t fb;
	rsc_sym_t delta;
	rsc_sym_t acc;
	rsc_sym_t oddSum;
	rsc_sym_t lamSum;
	rsc_tab_t base;
	logic [15:0] idx;
	logic hit;
	logic [15:0] rdVal;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic wr;

	assign eLong = st.ctrl[`RSC_CF_ENC_MODE]; // R21
	assign dLong = st.ctrl[`RSC_CF_DEC_MODE]; // R20
	assign encNsym = eLong ? `RSC_LONG_NSYM : `RSC_SHORT_NSYM;
	assign decNsym = dLong ? `RSC_LONG_NSYM : `RSC_SHORT_NSYM;
	// Pair writes own the port; encoder fetch beats decoder fetch
	assign fixWrite = (st.fix == FIX_WLOC) || (st.fix == FIX_WMAG);
	assign encGo = st.ctrl[`RSC_CF_ENC_ENA] && !st.ctrl[`RSC_CF_ENC_FLASH] && st.enc.left != 16'h0000
		&& !st.enc.have && !st.enc.pend && !fixWrite;
	assign decGo = st.ctrl[`RSC_CF_DEC_ENA] && !st.ctrl[`RSC_CF_DEC_FLASH] && st.dec.left != 16'h0000
		&& !st.dec.have && !st.dec.pend && !fixWrite && !encGo;
	assign idx = paddr[17:2];
	assign hit = paddr[1:0] == 2'b00 && (paddr >> 18) == '0 && (idx == `RSC_IDX_STATUS || idx == `RSC_IDX_CONTROL
		|| idx == `RSC_IDX_ENC_PTR || idx == `RSC_IDX_ENC_LEN || idx == `RSC_IDX_DEC_PTR || idx == `RSC_IDX_DEC_LEN
		|| idx == `RSC_IDX_READ_PORT || idx == `RSC_IDX_TOTALS || idx == `RSC_IDX_SHARED);
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wval = (pwdata[15:0] & wmask);
	assign wr = psel && penable && pwrite && hit;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pready = psel && penable;
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign sharedPeriphIrq = st.irqEna && (st.corrFlag || st.decFlag || st.encFlag); // R12

	// Memory port: pair writes, else one word fetch
	always_comb begin
		memReq = '0;
		if (fixWrite) begin
			memReq.req = 1'b1;
			memReq.we = 1'b1;
			memReq.addr = st.decPtr[10:0] + {5'h00, st.pairs, st.fix == FIX_WMAG};
			memReq.wdata = (st.fix == FIX_WLOC) ? st.errLoc : {6'h00, st.errMag}; // R10
		end else if (encGo) begin
			memReq.req = 1'b1;
			memReq.addr = st.enc.addr;
		end else if (decGo) begin
			memReq.req = 1'b1;
			memReq.addr = st.dec.addr;
		end
	end

	// Register read view
	always_comb begin
		rdVal = '0;
		case (idx)
			`RSC_IDX_STATUS: begin
				rdVal[`RSC_ST_CLEAN] = st.clean;
				rdVal[`RSC_ST_HAS_ERR] = st.hasErr;
				rdVal[`RSC_ST_UNREC] = st.unrec;
				rdVal[`RSC_ST_FIX_A] = st.fixA;
				rdVal[`RSC_ST_FIX_BUSY] = st.fixBusy;
				rdVal[`RSC_ST_FIX_B] = st.fixB;
				rdVal[`RSC_ST_FIX_OVF] = st.fixOvf;
				rdVal[`RSC_ST_PAIRS] = st.pairCnt; // R14
			end
			`RSC_IDX_CONTROL: rdVal = st.ctrl;
			`RSC_IDX_ENC_PTR: rdVal = st.encPtr;
			`RSC_IDX_ENC_LEN: rdVal = st.encLen;
			`RSC_IDX_DEC_PTR: rdVal = st.decPtr;
			`RSC_IDX_DEC_LEN: rdVal = st.decLen;
			`RSC_IDX_READ_PORT: rdVal = st.readWord;
			`RSC_IDX_TOTALS: rdVal = {10'h000, st.totalCnt};
			`RSC_IDX_SHARED: begin
				rdVal[`RSC_XS_ENC_DONE] = st.encFlag; // R13
				rdVal[`RSC_XS_DEC_DONE] = st.decFlag;
				rdVal[`RSC_XS_CORR_DONE] = st.corrFlag;
				rdVal[`RSC_XS_IRQ_ENA] = st.irqEna;
			end
			default: rdVal = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		encSymV = 1'b0;
		decSymV = 1'b0;
		encSym = '0;
		decSym = '0;
		fb = '0;
		delta = '0;
		acc = '0;
		oddSum = '0;
		lamSum = '0;
		base = '0;
		// APB: read data captured in setup, answered next cycle
		if (psel && !penable) begin
			next_st.prdata = {16'h0000, rdVal};
			next_st.pslverr = !hit;
		end
		// Software writes; read-only registers ignore them
		if (wr) begin
			case (idx)
				`RSC_IDX_CONTROL: begin
					next_st.ctrl = (st.ctrl & ~wmask) | wval; // R20 R21
					if (!st.ctrl[`RSC_CF_ENC_ENA] && next_st.ctrl[`RSC_CF_ENC_ENA]) begin
						next_st.enc = '0;
						next_st.enc.left = st.encLen;
						next_st.enc.addr = st.encPtr[10:0];
					end
					if (!st.ctrl[`RSC_CF_DEC_ENA] && next_st.ctrl[`RSC_CF_DEC_ENA]) begin
						next_st.dec = '0;
						next_st.dec.left = st.decLen;
						next_st.dec.addr = st.decPtr[10:0];
					end
				end
				`RSC_IDX_ENC_PTR: next_st.encPtr = (st.encPtr & ~wmask) | wval;
				`RSC_IDX_ENC_LEN: next_st.encLen = (st.encLen & ~wmask) | wval;
				`RSC_IDX_DEC_PTR: next_st.decPtr = (st.decPtr & ~wmask) | wval;
				`RSC_IDX_DEC_LEN: next_st.decLen = (st.decLen & ~wmask) | wval;
				`RSC_IDX_SHARED: begin
					// Flags clear on write of one; a same-cycle event set below wins
					if (pstrb[1]) begin
						next_st.irqEna = pwdata[`RSC_XS_IRQ_ENA];
						next_st.corrFlag = st.corrFlag && !pwdata[`RSC_XS_CORR_DONE];
					end
					if (pstrb[0]) begin
						next_st.decFlag = st.decFlag && !pwdata[`RSC_XS_DEC_DONE];
						next_st.encFlag = st.encFlag && !pwdata[`RSC_XS_ENC_DONE];
					end
				end
				default: ;
			endcase
		end

		// Encoder feed: flash writes or big-endian bytes from memory
		if (st.enc.pend) begin
			next_st.enc.word = memRdata;
			next_st.enc.have = 1'b1;
			next_st.enc.lo = 1'b0;
			next_st.enc.pend = 1'b0;
		end
		if (encGo) begin
			next_st.enc.pend = 1'b1;
			next_st.enc.addr = st.enc.addr + 11'd1;
		end
		if (st.ctrl[`RSC_CF_ENC_ENA] && st.enc.left != 16'h0000) begin
			if (st.ctrl[`RSC_CF_ENC_FLASH]) begin
				encSymV = flashTx.valid;
				encSym = {2'b00, flashTx.data};
			end else if (st.enc.have) begin
				encSymV = 1'b1;
				encSym = {2'b00, st.enc.lo ? st.enc.word[7:0] : st.enc.word[15:8]}; // R25 R1
			end
		end
		// Systematic LFSR; start wipes the check symbols first
		if (encSymV) begin
			base = st.ctrl[`RSC_CF_ENC_START] ? '0 : st.par;
			next_st.ctrl[`RSC_CF_ENC_START] = 1'b0; // R23
			fb = encSym ^ base[encNsym - 6'd1];
			for (int i = 0; i < 33; i++) begin
				next_st.par[i] = (i < encNsym) ? ((i == 0 ? 10'h000 : base[i-1])
					^ gfMul(fb, eLong ? GEN_L[i] : GEN_S[i], eLong)) : 10'h000;
			end
			next_st.enc.left = st.enc.left - 16'd1;
			next_st.enc.have = !st.enc.lo && !st.ctrl[`RSC_CF_ENC_FLASH];
			next_st.enc.lo = !st.enc.lo;
		end
		if (st.ctrl[`RSC_CF_ENC_ENA] && st.enc.left == 16'h0000) begin
			next_st.ctrl[`RSC_CF_ENC_ENA] = 1'b0; // R25
			next_st.encFlag = 1'b1;
			next_st.enc.have = 1'b0;
		end

		// Decoder feed: flash reads or memory, bytes or wide words
		if (st.dec.pend) begin
			next_st.dec.word = memRdata;
			next_st.dec.have = 1'b1;
			next_st.dec.lo = 1'b0;
			next_st.dec.pend = 1'b0;
		end
		if (decGo) begin
			next_st.dec.pend = 1'b1;
			next_st.dec.addr = st.dec.addr + 11'd1;
		end
		if (st.ctrl[`RSC_CF_DEC_ENA] && st.dec.left != 16'h0000) begin
			if (st.ctrl[`RSC_CF_DEC_FLASH]) begin
				decSymV = flashRx.valid;
				decSym = {2'b00, flashRx.data};
			end else if (st.dec.have) begin
				decSymV = 1'b1;
				// Wide words carry check symbols in their low ten bits
				decSym = st.ctrl[`RSC_CF_DEC_WIDE] ? st.dec.word[9:0]
					: {2'b00, st.dec.lo ? st.dec.word[7:0] : st.dec.word[15:8]}; // R24 R9
			end
		end
		// Syndromes by Horner steps, in arrival order: data, then checks
		if (decSymV) begin
			base = st.ctrl[`RSC_CF_DEC_START] ? '0 : st.syn;
			next_st.ctrl[`RSC_CF_DEC_START] = 1'b0; // R23
			next_st.decCnt = (st.ctrl[`RSC_CF_DEC_START] ? 11'd0 : st.decCnt) + 11'd1; // R8
			for (int i = 0; i < 33; i++) begin
				next_st.syn[i] = (i < decNsym) ? (gfMul(base[i], dLong ? APOW_L[i] : APOW_S[i], dLong) ^ decSym)
					: 10'h000;
			end
			next_st.dec.left = st.dec.left - 16'd1;
			next_st.dec.have = !st.dec.lo && !st.ctrl[`RSC_CF_DEC_FLASH] && !st.ctrl[`RSC_CF_DEC_WIDE];
			next_st.dec.lo = !st.dec.lo;
		end
		if (st.ctrl[`RSC_CF_DEC_ENA] && st.dec.left == 16'h0000) begin
			next_st.ctrl[`RSC_CF_DEC_ENA] = 1'b0; // R24
			next_st.dec.have = 1'b0;
			// No decode-done while feeding wide check words
			if (!st.ctrl[`RSC_CF_DEC_WIDE]) begin
				next_st.decFlag = 1'b1;
			end
		end

		// Code end: verdict, then on errors the fix starts by itself
		if (st.ctrl[`RSC_CF_DEC_END]) begin
			next_st.ctrl[`RSC_CF_DEC_END] = 1'b0; // R22
			for (int i = 0; i < 33; i++) begin
				acc = acc | st.syn[i];
			end
			next_st.clean = (acc == 10'h000); // R19
			next_st.hasErr = (acc != 10'h000); // R18
			next_st.unrec = st.decCnt > (dLong ? `RSC_LONG_N : `RSC_SHORT_N); // R17
			if (acc != 10'h000) begin
				next_st.fix = FIX_BM; // R18
				next_st.lam = '0;
				next_st.lam[0] = 10'h001;
				next_st.prevB = next_st.lam;
				next_st.omg = '0;
				next_st.gamma = 10'h001;
				next_st.lenL = '0;
				next_st.step = '0;
				next_st.pairs = '0;
				next_st.roots = '0;
				next_st.pairCnt = '0;
				next_st.fixA = 1'b0;
				next_st.fixB = 1'b0;
				next_st.fixOvf = 1'b0;
				next_st.fixBusy = 1'b1; // R16
			end
			acc = '0;
		end else begin
			// ----------------------------------------------------------------
			// Fix: inversionless BM, evaluator, Chien search with Forney
			// ----------------------------------------------------------------
			unique case (st.fix)
				FIX_IDLE: ;
				FIX_BM: begin
					for (int j = 0; j < 33; j++) begin
						if (j <= st.step) begin
							delta = delta ^ gfMul(st.lam[j], st.syn[st.step - 6'(j)], dLong);
						end
					end
					for (int j = 0; j < 33; j++) begin
						next_st.lam[j] = gfMul(st.gamma, st.lam[j], dLong)
							^ (j > 0 ? gfMul(delta, st.prevB[j-1], dLong) : 10'h000);
						next_st.prevB[j] = (j > 0) ? st.prevB[j-1] : 10'h000;
					end
					if (delta != 10'h000 && {st.lenL, 1'b0} <= {1'b0, st.step}) begin
						next_st.prevB = st.lam;
						next_st.lenL = st.step + 6'd1 - st.lenL;
						next_st.gamma = delta;
					end
					next_st.step = st.step + 6'd1;
					if (st.step == decNsym - 6'd1) begin
						next_st.fix = FIX_OMEGA;
						next_st.step = '0;
						next_st.fixA = 1'b1; // R16
					end
				end
				FIX_OMEGA: begin
					for (int j = 0; j < 33; j++) begin
						if (j <= st.step) begin
							acc = acc ^ gfMul(st.syn[st.step - 6'(j)], st.lam[j], dLong);
						end
					end
					next_st.omg[st.step] = acc;
					next_st.step = st.step + 6'd1;
					if (st.step == decNsym - 6'd1) begin
						next_st.fix = FIX_CHIEN;
						next_st.chienPos = '0;
					end
				end
				FIX_CHIEN: begin
					for (int j = 0; j < 33; j++) begin
						lamSum = lamSum ^ st.lam[j];
						oddSum = oddSum ^ ((j % 2 == 1) ? st.lam[j] : 10'h000);
						acc = acc ^ st.omg[j];
						next_st.lam[j] = gfMul(st.lam[j], dLong ? AINV_L[j] : AINV_S[j], dLong);
						next_st.omg[j] = gfMul(st.omg[j], dLong ? AINV_L[j] : AINV_S[j], dLong);
					end
					next_st.chienPos = st.chienPos + 11'd1;
					if (st.chienPos + 11'd1 == st.decCnt) begin
						next_st.fix = FIX_END;
					end
					if (lamSum == 10'h000) begin
						next_st.roots = st.roots + 6'd1; // R10
						// Only data positions yield pairs; check positions are counted only
						if (st.chienPos >= 11'(decNsym)) begin
							next_st.errLoc = 16'(st.decCnt - 11'd1 - st.chienPos); // R10 R11
							next_st.errMag = gfMul(acc, gfInv(oddSum, dLong), dLong); // R3
							next_st.fix = FIX_WLOC;
						end
					end
				end
				FIX_WLOC: next_st.fix = FIX_WMAG;
				FIX_WMAG: begin
					next_st.pairs = st.pairs + 5'd1;
					next_st.fix = (st.chienPos == st.decCnt) ? FIX_END : FIX_CHIEN;
				end
				FIX_END: begin
					// Root count unequal to degree, or degree above t: beyond repair
					next_st.fixOvf = (st.roots != st.lenL) || st.lenL > (dLong ? `RSC_LONG_T : `RSC_SHORT_T); // R15 R3
					next_st.pairCnt = st.pairs; // R14
					next_st.totalCnt = st.roots; // R10
					next_st.fixBusy = 1'b0;
					next_st.fixB = 1'b1;
					next_st.corrFlag = 1'b1; // R16 R13
					next_st.fix = FIX_IDLE;
				end
				default: next_st.fix = FIX_IDLE;
			endcase
		end

		// Read port: check word picked by the select field
		next_st.readWord = '0;
		if (eLong) begin
			// Long map packs ten-bit check symbols c0..c7 into five words
			case (st.ctrl[`RSC_CF_PAR_SEL])
				4'h0: next_st.readWord = {st.par[7][7:0], st.par[6][5:0], st.par[7][9:8]}; // R6 R5 R4
				4'h1: next_st.readWord = {st.par[5][3:0], st.par[6][9:6], st.par[4][1:0], st.par[5][9:4]};
				4'h2: next_st.readWord = {st.par[4][9:2], st.par[3][7:0]};
				4'h3: next_st.readWord = {st.par[2][5:0], st.par[3][9:8], st.par[1][3:0], st.par[2][9:6]};
				4'h4: next_st.readWord = {st.par[0][1:0], st.par[1][9:4], st.par[0][9:2]};
				default: next_st.readWord = '0;
			endcase
		end else begin
			// Earlier check symbol in the high byte
			next_st.readWord = {st.par[6'd31 - {1'b0, st.ctrl[`RSC_CF_PAR_SEL], 1'b0}][7:0],
				st.par[6'd30 - {1'b0, st.ctrl[`RSC_CF_PAR_SEL], 1'b0}][7:0]}; // R7 R26
		end
	end

	// Single state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // rsc_codec

// *** rsc_mem_model.sv ***
`timescale 1ns/100ps
module rsc_mem_model (
	// Clock
	input wire logic clk,
	// Request and answer
	input wire rsc_pkg::rsc_mem_req_s memReq,
	output logic [15:0] memRdata
);
	import rsc_pkg::*;
	logic [15:0] mem [2048];
	logic [15:0] lastWord;
	logic rdNow;
	// Answer one cycle after a read; otherwise show the inverse so stale data never passes
	always @(posedge clk) begin
		rdNow <= memReq.req && !memReq.we;
		if (memReq.req && memReq.we) mem[memReq.addr] <= memReq.wdata;
		if (memReq.req && !memReq.we) lastWord <= mem[memReq.addr];
	end
	assign memRdata = rdNow ? lastWord : ~lastWord;
endmodule // rsc_mem_model

// *** rsc_codec_sva.sv ***
`timescale 1ns/100ps
module rsc_codec_sva #(
	parameter int APB_AW = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Memory and interrupt
	input wire rsc_pkg::rsc_mem_req_s memReq,
	input wire logic sharedPeriphIrq
);
	import rsc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic enaShadow;
	// Shadow of the irq enable, rebuilt from bus writes
	always_ff @(posedge clk) begin
		if (rst) enaShadow <= 1'b0;
		else if (psel && penable && pwrite && paddr == 32'h0003_f1f8 && pstrb[1]) enaShadow <= pwdata[14];
	end
	sequence acc_s; psel && penable; endsequence
	sequence rd_s; psel && penable && !pwrite; endsequence
	irq_gate_a: assert property (sharedPeriphIrq |-> enaShadow) else $error("irq without enable");
	hold_data_a: assert property (acc_s |=> $stable(prdata)) else $error("read data moved");
	upper_zero_a: assert property (rd_s |-> prdata[31:16] == 16'h0000) else $error("upper half set");
	misalign_a: assert property (acc_s ##0 paddr[1:0] != 2'b00 |-> pslverr) else $error("no slave error");
	status_ok_a: assert property (rd_s ##0 paddr == 32'h0003_f1c0 |-> !pslverr && prdata[15:13] == 3'b000
		&& !prdata[7]) else $error("status layout");
	quiet_reset_a: assert property ($fell(rst) |-> !sharedPeriphIrq && !memReq.req) else $error("busy after reset");
	wdata_fit_a: assert property (memReq.req && memReq.we |-> memReq.wdata[15:11] == 5'h00) else $error("pair wide");
	fetch_once_a: assert property (memReq.req && !memReq.we |=> !(memReq.req && !memReq.we
		&& memReq.addr == $past(memReq.addr))) else $error("fetch repeated");
endmodule // rsc_codec_sva
bind rsc_codec rsc_codec_sva #(.APB_AW(APB_AW)) u_rsc_codec_sva (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
	.memReq(memReq), .sharedPeriphIrq(sharedPeriphIrq));

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
	import rsc_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, watch, err;
	logic [31:0] paddr, pwdata, prdata, rdv, seed;
	logic [3:0] pstrb;
	logic [15:0] memRdata, keep;
	rsc_mem_req_s memReq;
	rsc_flash_s flashTx, flashRx;
	logic [31:0] expQ [$];
	int error_cnt, total_checks;
	rsc_codec u_rsc_codec (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
		.memRdata(memRdata), .flashTx(flashTx), .flashRx(flashRx), .sharedPeriphIrq(irq));
	rsc_mem_model u_rsc_mem_model (.clk(clk), .memReq(memReq), .memRdata(memRdata));
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done;
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] ba(input logic [15:0] i);
		return {14'h0000, i, 2'b00};
	endfunction
	// One transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, d, input logic c, input logic [31:0] e);
		if (c) expQ.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		watch <= c;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		watch <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		apb(1'b1, ba(i), d, 1'b0, 32'h0000_0000);
	endtask
	task automatic rd(input logic [15:0] i, input logic [31:0] e);
		apb(1'b0, ba(i), 32'h0000_0000, 1'b1, e);
	endtask
	// Polls the shared status; the watchdog bounds the wait
	task automatic poll(input int b);
		do apb(1'b0, ba(16'hfc7e), 32'h0000_0000, 1'b0, 32'h0000_0000);
		while (rdv[b] !== 1'b1);
	endtask
	// Decode 52 symbols from address 0, then give code end
	task automatic decode;
		wr(16'hfc75, 32'h0000_0034);
		wr(16'hfc71, 32'h0000_0600);
		poll(7);
		wr(16'hfc7e, 32'h0000_4080);
		wr(16'hfc71, 32'h0000_0800);
	endtask
	// Checked reads: oldest note against what the bus returns
	always @(posedge clk) begin
		if (psel && penable && !pwrite && watch && expQ.size() > 0) chk("prdata", prdata, expQ.pop_front());
	end
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Generous: whole flow needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done;
	end
	initial begin
		{rst, psel, penable, pwrite, watch} = 5'h1f & 5'h10;
		{paddr, pwdata} = 64'h0000_0000_0000_0000;
		pstrb = 4'hf;
		flashTx = '0;
		flashRx = '0;
		seed = 32'hbb18_13a6;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rd(16'hfc70 + i[15:0], 32'h0000_0000);
		apb(1'b0, 32'h0003_f1e8, 32'h0000_0000, 1'b0, 32'h0000_0000);
		chk("unmapped", {31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b0, 32'h0003_f1c6, 32'h0000_0000, 1'b0, 32'h0000_0000);
		chk("misaligned", {31'h0000_0000, err}, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(16'hfc70 + i[15:0], seed & 32'h0000_30f0);
			rd(16'hfc70 + i[15:0], i < 1 ? 32'h0000_0000 : seed & 32'h0000_30f0);
			wr(16'hfc70 + i[15:0], 32'h0000_0000);
		end
		wr(16'hfc7e, 32'h0000_4000);
		rd(16'hfc7e, 32'h0000_4000);
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			u_rsc_mem_model.mem[i] = seed[15:0];
		end
		keep = u_rsc_mem_model.mem[3];
		wr(16'hfc73, 32'h0000_0014);
		wr(16'hfc71, 32'h0000_0006);
		poll(6);
		chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
		rd(16'hfc71, 32'h0000_0000);
		wr(16'hfc7e, 32'h0000_4040);
		chk("irq", {31'h0000_0000, irq}, 32'h0000_0000);
		for (int w = 0; w < 16; w++) begin
			wr(16'hfc71, {24'h00_0000, w[3:0], 4'h0});
			apb(1'b0, ba(16'hfc76), 32'h0000_0000, 1'b0, 32'h0000_0000);
			u_rsc_mem_model.mem[10 + w] = rdv[15:0];
		end
		wr(16'hfc71, 32'h0000_0051);
		rd(16'hfc76, 32'h0000_0000);
		decode;
		rd(16'hfc71, 32'h0000_0000);
		rd(16'hfc70, 32'h0000_0001);
		u_rsc_mem_model.mem[3] = keep ^ 16'h5a00;
		decode;
		poll(8);
		rd(16'hfc70, 32'h0000_012a);
		rd(16'hfc7d, 32'h0000_0001);
		chk("location", {16'h0000, u_rsc_mem_model.mem[0]}, 32'h0000_0006);
		chk("magnitude", {16'h0000, u_rsc_mem_model.mem[1]}, 32'h0000_005a);
		u_rsc_mem_model.mem[3][15:8] ^= u_rsc_mem_model.mem[1][7:0];
		chk("repaired", {16'h0000, u_rsc_mem_model.mem[3]}, {16'h0000, keep});
		wr(16'hfc75, 32'h0000_0001);
		wr(16'hfc71, 32'h0000_1200);
		rd(16'hfc70, 32'h0000_012a);
		rd(16'hfc71, 32'h0000_1000);
		rd(16'hfc7e, 32'h0000_4100);
		test_done;
	end
endmodule // tb
